// file: rtl/hsc_pkg.sv
// Package for the remote high-speed counter: command codes, word layouts and timing counts.
// Assumes a 25 MHz system clock and word-level access from the field bus adapter.
package hsc_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned PERIOD_UNIT_MS = 100;
	localparam int unsigned UNIT_CYCLES = CLK_HZ / 1000 * PERIOD_UNIT_MS;
	localparam logic [15:0] CMD_NONE = 16'h0000;
	localparam logic [15:0] CMD_THR1 = 16'h0001;
	localparam logic [15:0] CMD_THR2 = 16'h0002;
	localparam logic [15:0] CMD_SETPT = 16'h0003;
	localparam logic [15:0] CMD_WINDOW = 16'h0004;
	localparam logic [15:0] CMD_CLEAR = 16'h0005;
	localparam logic [15:0] CMD_LOAD = 16'h0006;
	localparam logic [15:0] CMD_PERIOD = 16'h0190;
	localparam logic [15:0] CMD_CHAN_A = 16'h019A;
	localparam logic [15:0] CMD_CHAN_B = 16'h01A4;
	localparam logic [15:0] CMD_CHAN_C = 16'h01AE;
	localparam logic [7:0] WINDOW_RESET = 8'h02;
	localparam logic [15:0] PERIOD_RESET = 16'h000A;
	localparam logic [2:0] MODE_QUAD = 3'h1;
	localparam logic [2:0] MODE_UPDOWN = 3'h2;
	localparam logic [2:0] MODE_ADD = 3'h3;
	localparam logic [2:0] MODE_TRIPLE = 3'h4;
	localparam logic [2:0] MODE_FREQ = 3'h5;
	localparam int unsigned XFER_BIT = 0;
	localparam int unsigned CFG_SW_LSB = 9;

	typedef struct packed {
		logic [15:0] cmd;
		logic [15:0] param1;
		logic [15:0] param2;
	} cmd_word_s;

	typedef struct packed {
		logic set;
		logic rst;
		logic ref_on;
		logic valid;
	} ctl_in_s;

	typedef struct packed {
		logic eq_zero;
		logic gt_zero;
		logic eq_thr1;
		logic gt_thr1;
		logic eq_thr2;
		logic gt_thr2;
	} cmp_s;
endpackage

// file: rtl/remote_high_speed_counter.sv
// Command handling and counting logic of the remote high-speed counter.
// Assumes synchronous counting and control inputs and a command word held stable by the bus adapter.
//
// Functional notes
// - Config bits 9..13 report rear switches.
// - Status bit 0 low while command executes.
// - Codes 1,2 load thresholds, high then low.
// - Code 3 stores setpoint, loaded on set.
// - Code 4 loads target window, 0 to 255.
// - Target window defaults to two after reset.
// - Code 5 clears counter regardless of qualify.
// - Code 6 loads counter regardless of qualify.
// - Counter compared with zero, thresholds, window.
// - Codes 410..413 act on counter A.
// - Codes 420..423 act on counter B.
// - Codes 430..433 act on counter C.
// - Code 400 sets shared period, times 100ms.
// - Period ranges 100 ms to 6553.5 s.
// - Falling C clears counter with reference, qualify.
// - Mode 2: A increments, B decrements.
// - Mode 3: A and B both increment.
// - Mode 4 counters wrap without overflow error.
// - Mode 4 set/reset inputs act on all three.
// - Mode 4 comparisons are signed.
// - Qualify off forces comparison outputs low.
// - Split mode high word follows low wraps.
`timescale 1ns/100ps
module remote_high_speed_counter
	import hsc_pkg::*;
#(
	parameter int unsigned UNIT_CYCLES_P = UNIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire cmd_word_s cmd_i,
	input wire logic [2:0] mode_i,
	input wire logic [4:0] switch_i,
	input wire logic rising_i,
	input wire logic both_edges_i,
	input wire logic split_i,
	input wire logic in_a_i,
	input wire logic in_b_i,
	input wire logic in_c_i,
	input wire ctl_in_s ctl_i,
	output cmp_s cmp_o,
	output logic up_o,
	output logic overflow_o,
	output logic [15:0] count_hi_o,
	output logic [15:0] count_lo_o,
	output logic [15:0] count_c_o,
	output logic [15:0] status_o,
	output logic [15:0] config_o
);
	typedef enum logic [1:0] {IDLE, EXEC, DONE} xfer_e;
	xfer_e state_reg;
	logic [15:0] last_cmd_reg;
	logic [31:0] thr1_reg, thr2_reg, setpt_reg, count_reg;
	logic [7:0] window_reg;
	logic [15:0] period_reg;
	logic [15:0] cnt16_reg [3];
	logic [15:0] thr16_reg [3];
	logic [15:0] set16_reg [3];
	logic [2:0] a_reg, b_reg, c_reg;
	logic set_reg, rst_reg;
	cmp_s cmp_reg;
	logic up_reg, ovf_reg;
	logic [31:0] div_reg;
	logic [15:0] unit_reg;
	logic [15:0] freq_acc_reg [3];
	logic [15:0] freq_reg [3];

	// The command is taken on its change, so a repeated code needs the zero in between.
	wire logic new_cmd = (cmd_i.cmd != last_cmd_reg) && (cmd_i.cmd != CMD_NONE);
	wire logic mode_32 = (mode_i == MODE_QUAD) || (mode_i == MODE_UPDOWN) || (mode_i == MODE_ADD);
	wire logic mode_16 = (mode_i == MODE_TRIPLE) || (mode_i == MODE_FREQ);
	wire logic exec = (state_reg == EXEC);
	wire logic [31:0] param32 = {cmd_i.param1, cmd_i.param2};
	wire logic a_rise = a_reg[1] & ~a_reg[2];
	wire logic a_fall = ~a_reg[1] & a_reg[2];
	wire logic b_rise = b_reg[1] & ~b_reg[2];
	wire logic b_fall = ~b_reg[1] & b_reg[2];
	wire logic c_rise = c_reg[1] & ~c_reg[2];
	wire logic c_fall = ~c_reg[1] & c_reg[2];
	wire logic a_edge = both_edges_i ? (a_rise | a_fall) : (rising_i ? a_rise : a_fall);
	wire logic b_edge = both_edges_i ? (b_rise | b_fall) : (rising_i ? b_rise : b_fall);
	// Quadrature: A edge with A!=B or B edge with A==B counts up.
	wire logic q_up = ((a_rise | a_fall) & (a_reg[1] != b_reg[1])) | ((b_rise | b_fall) & (a_reg[1] == b_reg[1]));
	wire logic q_dn = ((a_rise | a_fall) & (a_reg[1] == b_reg[1])) | ((b_rise | b_fall) & (a_reg[1] != b_reg[1]));
	wire logic inc_q = (mode_i == MODE_QUAD) & q_up & ~q_dn;
	wire logic dec_q = (mode_i == MODE_QUAD) & q_dn & ~q_up;
	wire logic inc_u = (mode_i == MODE_UPDOWN) & a_edge & ~b_edge;
	wire logic dec_u = (mode_i == MODE_UPDOWN) & b_edge & ~a_edge;
	wire logic [1:0] add_n = (mode_i == MODE_ADD) ? {1'b0, a_edge} + {1'b0, b_edge} : 2'h0;
	wire logic zero_mark = c_fall & ctl_i.ref_on & ctl_i.valid;
	wire logic set_edge = ctl_i.set & ~set_reg;
	wire logic rst_edge = ctl_i.rst & ~rst_reg;
	wire logic [31:0] half_win = {25'h0000000, window_reg[7:1]};
	wire logic [31:0] cnt_step = count_reg + {30'h00000000, add_n} + {31'h00000000, inc_q | inc_u};
	wire logic [31:0] cnt_next = cnt_step - {31'h00000000, dec_q | dec_u};
	wire logic lo_wrap_up = (count_reg[15:0] == 16'h7FFF) && (cnt_next[15:0] == 16'h8000);
	wire logic lo_wrap_dn = (count_reg[15:0] == 16'h8000) && (cnt_next[15:0] == 16'h7FFF);
	wire logic ovf32 = (count_reg == 32'hFFFFFFFF && (inc_q | inc_u | add_n != 2'h0)) ||
		(count_reg == 32'h00000000 && (dec_q | dec_u));
	wire logic unit_tick = (div_reg == UNIT_CYCLES_P - 1);
	wire logic period_end = unit_tick && (unit_reg + 16'h0001 >= period_reg);
	wire logic [2:0] in_rise = {c_rise, b_rise, a_rise};

	function automatic logic in_win(input logic [31:0] v, input logic [31:0] t, input logic [31:0] h);
		logic [31:0] d;
		d = (v >= t) ? v - t : t - v;
		return d <= h;
	endfunction

	function automatic logic in_win16(input logic [15:0] v, input logic [15:0] t, input logic [7:0] w);
		logic signed [17:0] d;
		d = $signed({v[15], v[15], v}) - $signed({t[15], t[15], t});
		return (d <= $signed({11'h000, w[7:1]})) && (d >= -$signed({11'h000, w[7:1]}));
	endfunction

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= IDLE;
			last_cmd_reg <= CMD_NONE;
		end else begin
			last_cmd_reg <= cmd_i.cmd;
			unique case (state_reg)
				IDLE, DONE: if (new_cmd) state_reg <= EXEC;
				EXEC: state_reg <= DONE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			thr1_reg <= 32'h00000000;
			thr2_reg <= 32'h00000000;
			setpt_reg <= 32'h00000000;
			window_reg <= WINDOW_RESET;
			period_reg <= PERIOD_RESET;
		end else if (exec && mode_32) begin
			if (last_cmd_reg == CMD_THR1) thr1_reg <= param32;
			if (last_cmd_reg == CMD_THR2) thr2_reg <= param32;
			if (last_cmd_reg == CMD_SETPT) setpt_reg <= param32;
			if (last_cmd_reg == CMD_WINDOW) window_reg <= cmd_i.param2[7:0];
		end else if (exec && mode_i == MODE_FREQ && last_cmd_reg == CMD_PERIOD && cmd_i.param2 != 16'h0000) begin
			period_reg <= cmd_i.param2;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			a_reg <= 3'h0;
			b_reg <= 3'h0;
			c_reg <= 3'h0;
			set_reg <= 1'b0;
			rst_reg <= 1'b0;
		end else begin
			a_reg <= {a_reg[1:0], in_a_i};
			b_reg <= {b_reg[1:0], in_b_i};
			c_reg <= {c_reg[1:0], in_c_i};
			set_reg <= ctl_i.set;
			rst_reg <= ctl_i.rst;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count_reg <= 32'h00000000;
			up_reg <= 1'b1;
		end else if (exec && mode_32 && last_cmd_reg == CMD_CLEAR) begin
			count_reg <= 32'h00000000;
		end else if (exec && mode_32 && last_cmd_reg == CMD_LOAD) begin
			count_reg <= param32;
		end else if (mode_32 && zero_mark) begin
			count_reg <= 32'h00000000;
		end else if (mode_32 && set_edge) begin
			count_reg <= setpt_reg;
		end else if (mode_32) begin
			if (split_i && lo_wrap_up) count_reg <= {count_reg[31:16] + 16'h0001, cnt_next[15:0]};
			else if (split_i && lo_wrap_dn) count_reg <= {count_reg[31:16] - 16'h0001, cnt_next[15:0]};
			else count_reg <= cnt_next;
			if (inc_q | inc_u | (add_n != 2'h0)) up_reg <= 1'b1;
			else if (dec_q | dec_u) up_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			div_reg <= 32'h00000000;
			unit_reg <= 16'h0000;
		end else if (unit_tick) begin
			div_reg <= 32'h00000000;
			unit_reg <= period_end ? 16'h0000 : unit_reg + 16'h0001;
		end else begin
			div_reg <= div_reg + 32'h00000001;
		end
	end

	generate
		for (genvar i = 0; i < 3; i++) begin : g_chan
			wire logic [15:0] base = CMD_CHAN_A + 16'(i * 10);
			wire logic hit = exec && mode_16 && (last_cmd_reg >= base) && (last_cmd_reg <= base + 16'h0003);
			wire logic [1:0] sub = 2'(last_cmd_reg - base);
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					cnt16_reg[i] <= 16'h0000;
					thr16_reg[i] <= 16'h0000;
					set16_reg[i] <= 16'h0000;
					freq_acc_reg[i] <= 16'h0000;
					freq_reg[i] <= 16'h0000;
				end else begin
					if (hit && sub == 2'h2) set16_reg[i] <= cmd_i.param2;
					if (hit && sub == 2'h3) thr16_reg[i] <= cmd_i.param2;
					if (hit && sub == 2'h0) cnt16_reg[i] <= 16'h0000;
					else if (hit && sub == 2'h1) cnt16_reg[i] <= cmd_i.param2;
					else if (mode_16 && rst_edge) cnt16_reg[i] <= 16'h0000;
					else if (mode_16 && set_edge && ctl_i.valid) cnt16_reg[i] <= set16_reg[i];
					else if (mode_i == MODE_TRIPLE && in_rise[i]) cnt16_reg[i] <= cnt16_reg[i] + 16'h0001;
					if (mode_i == MODE_FREQ) begin
						if (period_end) begin
							freq_reg[i] <= freq_acc_reg[i] + {15'h0000, in_rise[i]};
							freq_acc_reg[i] <= 16'h0000;
						end else if (in_rise[i]) begin
							freq_acc_reg[i] <= freq_acc_reg[i] + 16'h0001;
						end
					end
				end
			end
		end
	endgenerate

	wire logic [15:0] v16 [3];
	assign v16[0] = (mode_i == MODE_FREQ) ? freq_reg[0] : cnt16_reg[0];
	assign v16[1] = (mode_i == MODE_FREQ) ? freq_reg[1] : cnt16_reg[1];
	assign v16[2] = (mode_i == MODE_FREQ) ? freq_reg[2] : cnt16_reg[2];
	wire logic eq16 [3];
	wire logic gt16 [3];
	assign eq16[0] = in_win16(v16[0], thr16_reg[0], window_reg);
	assign eq16[1] = in_win16(v16[1], thr16_reg[1], window_reg);
	assign eq16[2] = in_win16(v16[2], thr16_reg[2], window_reg);
	assign gt16[0] = $signed(v16[0]) > $signed(thr16_reg[0]) && !eq16[0];
	assign gt16[1] = $signed(v16[1]) > $signed(thr16_reg[1]) && !eq16[1];
	assign gt16[2] = $signed(v16[2]) > $signed(thr16_reg[2]) && !eq16[2];

	cmp_s cmp_next;
	always_comb begin
		if (mode_16) begin
			cmp_next.eq_thr1 = eq16[0];
			cmp_next.gt_thr1 = gt16[0];
			cmp_next.eq_thr2 = eq16[1];
			cmp_next.gt_thr2 = gt16[1];
			cmp_next.eq_zero = eq16[2];
			cmp_next.gt_zero = gt16[2];
		end else begin
			cmp_next.eq_zero = in_win(count_reg, 32'h00000000, half_win);
			cmp_next.gt_zero = count_reg > half_win;
			cmp_next.eq_thr1 = in_win(count_reg, thr1_reg, half_win);
			cmp_next.gt_thr1 = count_reg > thr1_reg + half_win;
			cmp_next.eq_thr2 = in_win(count_reg, thr2_reg, half_win);
			cmp_next.gt_thr2 = count_reg > thr2_reg + half_win;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cmp_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			cmp_reg <= cmp_next;
			// Overflow is sticky until a clear or load command, so a short error is never missed.
			if (mode_32 && !split_i && ovf32) ovf_reg <= 1'b1;
			else if (exec && (last_cmd_reg == CMD_CLEAR || last_cmd_reg == CMD_LOAD)) ovf_reg <= 1'b0;
		end
	end

	assign cmp_o = ctl_i.valid ? cmp_reg : '0;
	assign up_o = ctl_i.valid & up_reg;
	assign overflow_o = ovf_reg;
	assign count_hi_o = mode_16 ? v16[0] : count_reg[31:16];
	assign count_lo_o = mode_16 ? v16[1] : count_reg[15:0];
	assign count_c_o = v16[2];
	// Internal comparison bits stay visible in the status word while outputs are gated.
	assign status_o = {1'b0, up_reg, cmp_reg.gt_thr2, cmp_reg.eq_thr2, cmp_reg.gt_thr1, cmp_reg.eq_thr1,
		cmp_reg.gt_zero, cmp_reg.eq_zero, 3'h0, ctl_i.valid, ctl_i.ref_on, ctl_i.rst, ctl_i.set,
		(state_reg != EXEC)};
	assign config_o = {ovf_reg, 1'b0, switch_i, split_i, 8'h00};

	// The controller polls the flag, so busy must last exactly one cycle and then read free.
	sequence busy_then_free_s;
		!status_o[XFER_BIT] ##1 status_o[XFER_BIT];
	endsequence

	AST_BUSY_ONE: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(exec) |-> busy_then_free_s) else $error("Transfer flag not one cycle busy.");
	AST_FREE: assert property (@(posedge clk_i) disable iff (srst_i)
		state_reg == DONE |-> status_o[XFER_BIT]) else $error("Transfer flag not free after execution.");
	AST_THR2: assert property (@(posedge clk_i) disable iff (srst_i)
		exec && mode_32 && last_cmd_reg == CMD_THR2 |=> thr2_reg == $past(param32)) else $error("Threshold two failed.");
	AST_SETPT: assert property (@(posedge clk_i) disable iff (srst_i)
		exec && mode_32 && last_cmd_reg == CMD_SETPT |=> setpt_reg == $past(param32)) else $error("Setpoint failed.");
	AST_SET_LOAD: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_32 && set_edge && !zero_mark && !exec |=> count_reg == $past(setpt_reg)) else $error("Set input failed.");
	AST_WINDOW: assert property (@(posedge clk_i) disable iff (srst_i)
		exec && mode_32 && last_cmd_reg == CMD_WINDOW |=> window_reg == $past(cmd_i.param2[7:0]))
		else $error("Window load failed.");
	AST_EQZ: assert property (@(posedge clk_i) disable iff (srst_i)
		!mode_16 && count_reg == 32'h00000000 |=> cmp_reg.eq_zero) else $error("Zero compare failed.");
	AST_PERIOD: assert property (@(posedge clk_i) disable iff (srst_i)
		exec && mode_i == MODE_FREQ && last_cmd_reg == CMD_PERIOD && cmd_i.param2 != 16'h0000
		|=> period_reg == $past(cmd_i.param2)) else $error("Period load failed.");
	AST_UPDOWN: assert property (@(posedge clk_i) disable iff (srst_i)
		inc_u && !exec && !zero_mark && !set_edge && !split_i |=> count_reg == $past(count_reg) + 32'h00000001)
		else $error("Up count failed.");
	AST_ADD: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_i == MODE_ADD && !exec && !zero_mark && !set_edge && !split_i
		|=> count_reg == $past(count_reg) + {30'h00000000, $past(add_n)}) else $error("Add count failed.");
	AST_WRAP16: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_i == MODE_TRIPLE && cnt16_reg[0] == 16'h7FFF && in_rise[0] && !g_chan[0].hit && !rst_edge && !set_edge
		|=> cnt16_reg[0] == 16'h8000) else $error("Counter A did not wrap.");
	AST_RST16: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_16 && rst_edge && !exec |=> cnt16_reg[0] == 16'h0000 && cnt16_reg[1] == 16'h0000 && cnt16_reg[2] == 16'h0000)
		else $error("Reset input failed.");
	AST_SIGNED: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_16 && $signed(v16[0]) < $signed(thr16_reg[0]) |=> !cmp_reg.gt_thr1) else $error("Signed compare failed.");
	AST_SPLIT_UP: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_32 && split_i && lo_wrap_up && !exec && !zero_mark && !set_edge
		|=> count_reg[31:16] == $past(count_reg[31:16]) + 16'h0001) else $error("High word not incremented.");
	AST_SPLIT_DN: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_32 && split_i && lo_wrap_dn && !exec && !zero_mark && !set_edge
		|=> count_reg[31:16] == $past(count_reg[31:16]) - 16'h0001) else $error("High word not decremented.");
	AST_WINDOW_DEF: assert property (@(posedge clk_i)
		srst_i |=> window_reg == 8'h02) else $error("Window reset value wrong.");
	AST_CLEAR: assert property (@(posedge clk_i) disable iff (srst_i)
		exec && mode_32 && last_cmd_reg == CMD_CLEAR |=> count_reg == 32'h00000000) else $error("Clear failed.");
	AST_LOAD: assert property (@(posedge clk_i) disable iff (srst_i)
		exec && mode_32 && last_cmd_reg == CMD_LOAD |=> count_reg == $past(param32)) else $error("Load failed.");
	AST_THR1: assert property (@(posedge clk_i) disable iff (srst_i)
		exec && mode_32 && last_cmd_reg == CMD_THR1 |=> thr1_reg == $past(param32)) else $error("Threshold failed.");
	AST_GATE: assert property (@(posedge clk_i) disable iff (srst_i)
		!ctl_i.valid |-> cmp_o == '0 && !up_o) else $error("Outputs not gated.");
	AST_ZMARK: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_32 && zero_mark && !exec |=> count_reg == 32'h00000000) else $error("Zero mark missed.");
	AST_CFG: assert property (@(posedge clk_i) disable iff (srst_i)
		config_o[13:9] == switch_i) else $error("Switch bits wrong.");
	AST_WRAP: assert property (@(posedge clk_i) disable iff (srst_i)
		mode_i == MODE_TRIPLE && $changed(cnt16_reg[0]) |-> !$rose(ovf_reg)) else $error("Wrap raised error.");
endmodule

// file: tb/ctrl_model.sv
// Central controller model: writes command and parameter words as the field bus adapter would.
// Assumes the counter status word is visible and that the caller starts at a falling clock edge.
`timescale 1ns/100ps
module ctrl_model
	import hsc_pkg::*;
(
	input wire logic clk_i,
	input wire logic [15:0] status_i,
	output cmd_word_s cmd_o
);
	initial cmd_o = '0;

	// Parameters are flipped while no command is posted, so stale words never pass for valid data.
	task automatic send(input logic [15:0] c, input logic [15:0] p1, input logic [15:0] p2,
		output logic busy, output logic free);
		@(negedge clk_i);
		cmd_o = '{cmd: CMD_NONE, param1: ~cmd_o.param1, param2: ~cmd_o.param2};
		repeat (2) @(negedge clk_i);
		cmd_o = '{cmd: c, param1: p1, param2: p2};
		@(negedge clk_i);
		busy = status_i[XFER_BIT];
		@(negedge clk_i);
		free = status_i[XFER_BIT];
		repeat (2) @(negedge clk_i);
	endtask

	task automatic touch(input logic [15:0] p1, input logic [15:0] p2);
		@(negedge clk_i);
		cmd_o.param1 = p1;
		cmd_o.param2 = p2;
	endtask
endmodule

// file: tb/remote_high_speed_counter_test.sv
// Self-checking bench for the remote high-speed counter.
// Assumes the controller model in ctrl_model.sv and a shortened measurement unit of UC cycles.
`timescale 1ns/100ps
module remote_high_speed_counter_test;
	import hsc_pkg::*;
	localparam int UC = 10;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [2:0] mode_i = MODE_UPDOWN;
	logic [4:0] switch_i = 5'h00;
	logic in_a_i = 1'b0;
	logic in_b_i = 1'b0;
	logic in_c_i = 1'b0;
	logic split_i = 1'b0;
	ctl_in_s ctl_i = '0;
	cmd_word_s cmd_w;
	cmp_s cmp_o;
	logic up_o;
	logic overflow_o;
	logic [15:0] count_hi_o, count_lo_o, count_c_o, status_o, config_o;
	int err_count = 0;
	int n_checks = 0;
	integer seed = 32'hd4e3;
	logic [31:0] v;
	logic [31:0] c0;
	logic bs, fr;
	int na, nb;
	int offs [5] = '{1, 2, -2, 3, 4};
	logic [1:0] pat [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

	always #20 clk_i = ~clk_i;

	remote_high_speed_counter #(.UNIT_CYCLES_P(UC)) DUT (.clk_i(clk_i), .srst_i(srst_i), .cmd_i(cmd_w),
		.mode_i(mode_i), .switch_i(switch_i), .rising_i(1'b1), .both_edges_i(1'b0), .split_i(split_i),
		.in_a_i(in_a_i), .in_b_i(in_b_i), .in_c_i(in_c_i), .ctl_i(ctl_i), .cmp_o(cmp_o), .up_o(up_o),
		.overflow_o(overflow_o), .count_hi_o(count_hi_o), .count_lo_o(count_lo_o), .count_c_o(count_c_o),
		.status_o(status_o), .config_o(config_o));
	ctrl_model CTRL (.clk_i(clk_i), .status_i(status_o), .cmd_o(cmd_w));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic send(input logic [15:0] c, input logic [31:0] val);
		CTRL.send(c, val[31:16], val[15:0], bs, fr);
		check(bs, 1'b0);
		check(fr, 1'b1);
	endtask

	// Called at a falling edge; each pulse is high for two cycles then low for two so the edge detector sees it whole.
	task automatic pulse(input logic a, input logic b, input logic c);
		{in_a_i, in_b_i, in_c_i} = {a, b, c};
		repeat (2) @(negedge clk_i);
		{in_a_i, in_b_i, in_c_i} = 3'h0;
		repeat (2) @(negedge clk_i);
	endtask

	function automatic logic [1:0] rel(input logic [31:0] cnt, input logic [31:0] thr, input int half);
		logic signed [31:0] d;
		d = cnt - thr;
		rel = (d <= half && d >= -half) ? 2'b10 : (d > half ? 2'b01 : 2'b00);
	endfunction

	task automatic endt(input string s);
		repeat (4) @(negedge clk_i);
		$display("test %s done", s);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		v = $random(seed);
		switch_i = v[4:0];
		repeat (6) @(negedge clk_i);
		srst_i = 1'b0;
		@(negedge clk_i);
		check(status_o[XFER_BIT], 1'b1);
		check(config_o[13:9], switch_i);
		endt("reset");
		v = $random(seed);
		send(CMD_LOAD, v);
		check({count_hi_o, count_lo_o}, v);
		CTRL.touch(~v[31:16], ~v[15:0]);
		repeat (4) @(negedge clk_i);
		check({count_hi_o, count_lo_o}, v);
		send(CMD_CLEAR, 32'h0);
		check({count_hi_o, count_lo_o}, 32'h0);
		endt("load");
		ctl_i.valid = 1'b1;
		na = 1 + ($random(seed) & 7);
		nb = $random(seed) & 3;
		repeat (na) pulse(1'b1, 1'b0, 1'b0);
		repeat (nb) pulse(1'b0, 1'b1, 1'b0);
		check({count_hi_o, count_lo_o}, na - nb);
		mode_i = MODE_ADD;
		repeat (na) pulse(1'b1, 1'b0, 1'b0);
		repeat (nb) pulse(1'b0, 1'b1, 1'b0);
		check({count_hi_o, count_lo_o}, 2 * na);
		ctl_i.ref_on = 1'b1;
		pulse(1'b0, 1'b0, 1'b1);
		@(negedge clk_i);
		check({count_hi_o, count_lo_o}, 32'h0);
		ctl_i.ref_on = 1'b0;
		endt("count");
		split_i = 1'b1;
		mode_i = MODE_UPDOWN;
		send(CMD_LOAD, 32'h00007FFF);
		check(config_o[8], 1'b1);
		pulse(1'b1, 1'b0, 1'b0);
		check({count_hi_o, count_lo_o}, 32'h00018000);
		pulse(1'b0, 1'b1, 1'b0);
		check({count_hi_o, count_lo_o}, 32'h00007FFF);
		split_i = 1'b0;
		mode_i = MODE_ADD;
		endt("split");
		v = $random(seed) & 32'h3FFFFFFF;
		send(CMD_THR1, v);
		send(CMD_THR2, v + 32'h100);
		foreach (offs[i]) begin
			if (i == 3)
				send(CMD_WINDOW, 32'h6);
			send(CMD_LOAD, v + offs[i]);
			check({cmp_o.eq_thr1, cmp_o.gt_thr1}, rel(v + offs[i], v, i < 3 ? 1 : 3));
			check({cmp_o.eq_thr2, cmp_o.gt_thr2}, rel(v + offs[i], v + 32'h100, i < 3 ? 1 : 3));
			check({cmp_o.eq_zero, cmp_o.gt_zero}, rel(v + offs[i], 0, i < 3 ? 1 : 3));
		end
		ctl_i.valid = 1'b0;
		repeat (3) @(negedge clk_i);
		check(cmp_o, '0);
		check(status_o[13:8], 6'h0A);
		ctl_i.valid = 1'b1;
		endt("compare");
		v = $random(seed) & 32'h3FFFFFFF;
		send(CMD_SETPT, v);
		ctl_i.set = 1'b1;
		repeat (4) @(negedge clk_i);
		check({count_hi_o, count_lo_o}, v);
		ctl_i.set = 1'b0;
		mode_i = MODE_QUAD;
		foreach (pat[i]) begin
			{in_a_i, in_b_i} = pat[i];
			repeat (3) @(negedge clk_i);
		end
		repeat (3) @(negedge clk_i);
		check({count_hi_o, count_lo_o} > v, 1'b1);
		check(up_o, 1'b1);
		endt("setpoint");
		mode_i = MODE_TRIPLE;
		c0 = $random(seed);
		send(CMD_CHAN_A + 16'h1, 32'h7FFF);
		send(CMD_CHAN_B + 16'h1, {16'h0, c0[15:0]});
		send(CMD_CHAN_C + 16'h1, {16'h0, c0[31:16]});
		check(count_lo_o, c0[15:0]);
		check(count_c_o, c0[31:16]);
		pulse(1'b1, 1'b0, 1'b0);
		check(count_hi_o, 16'h8000);
		check(overflow_o, 1'b0);
		send(CMD_CHAN_A, 32'h0);
		check(count_hi_o, 16'h0);
		send(CMD_CHAN_A + 16'h3, 32'hFFF0);
		send(CMD_CHAN_C + 16'h3, 32'hFFFF);
		ctl_i.rst = 1'b1;
		repeat (4) @(negedge clk_i);
		check({count_hi_o, count_lo_o, count_c_o}, 48'h0);
		ctl_i.rst = 1'b0;
		check({cmp_o.eq_thr1, cmp_o.gt_thr1}, rel(0, 32'hFFFFFFF0, 1));
		check({cmp_o.eq_zero, cmp_o.gt_zero}, rel(0, 32'hFFFFFFFF, 1));
		send(CMD_CHAN_A + 16'h2, {16'h0, c0[15:0]});
		ctl_i.set = 1'b1;
		repeat (4) @(negedge clk_i);
		check(count_hi_o, c0[15:0]);
		ctl_i.set = 1'b0;
		endt("triple");
		mode_i = MODE_FREQ;
		send(CMD_PERIOD, 32'h2);
		fork
			repeat (40) pulse(1'b1, 1'b0, 1'b0);
			begin
				repeat (100) @(negedge clk_i);
				check(count_hi_o, 2 * UC / 4);
			end
		join
		endt("frequency");
		finish_test();
	end

	initial begin
		repeat (6000) @(posedge clk_i);
		err_count++;
		finish_test();
	end
endmodule
